/* File: rtcs_defs.svh */
// Contract
// - The clock keeps a running time of day whose finest step is one millisecond.
// - A programmable alarm up to one month ahead raises an alarm event when the time equals it.
// - The calendar spans 9999 years and adds February 29 in leap years.
// - A periodic event fires at a software-selected rate from 1 Hz to 512 Hz.
// - Hours count 00 to 23 only, with no AM/PM mode.
// - Every time and calendar field is held, read and written as BCD digits.
// - A calibration clock from the timekeeping clock drives the debug return clock pin when software enables it.
// - At power down the block isolates itself and keeps counting from the backup supply.
// - Software picks the tamper mode: normally closed loop that flags on opening, or edge detection.
// - In edge mode tamper is flagged on a rising or a falling edge, as software configures.
// - A tamper event captures the current time to the millisecond and the date into stamp storage.
// - In the same moment the SRAM standby supply cut-off control is asserted.
// - One interrupt output is the OR of the alarm, tamper and periodic events.
// - Tamper control and status logic lives inside the clock block itself.
`ifndef RTCS_DEFS_SVH
`define RTCS_DEFS_SVH

// Timing
`define RTCS_CLK_PERIOD_NS  10
`define RTCS_MS_PERIOD_NS   1_000_000
`define RTCS_MS_CYCLES      (`RTCS_MS_PERIOD_NS / `RTCS_CLK_PERIOD_NS)
`define RTCS_BASE_PERIOD_NS 976_562
`define RTCS_BASE_CYCLES    (`RTCS_BASE_PERIOD_NS / `RTCS_CLK_PERIOD_NS)

// Register offsets
`define RTCS_A_CTRL    8'h00
`define RTCS_A_TIME    8'h04
`define RTCS_A_DATE    8'h08
`define RTCS_A_MSEC    8'h0C
`define RTCS_A_ALARM   8'h10
`define RTCS_A_STAT    8'h14
`define RTCS_A_MASK    8'h18
`define RTCS_A_TS_TIME 8'h1C
`define RTCS_A_TS_DATE 8'h20
`define RTCS_A_TS_MSEC 8'h24

// Control fields
`define RTCS_C_ALM_EN  0
`define RTCS_C_PER_EN  1
`define RTCS_C_TMP_EN  2
`define RTCS_C_TMP_MD  3
`define RTCS_C_TMP_POL 4
`define RTCS_C_CAL_EN  5
`define RTCS_C_PSEL_LO 6
`define RTCS_C_PSEL_HI 9
`define RTCS_C_RESTORE 10

// Status fields
`define RTCS_S_ALM     0
`define RTCS_S_TMP     1
`define RTCS_S_PER     2
`define RTCS_S_CUT     8
`define RTCS_S_ISO     9

// BCD limits and reset values
`define RTCS_MS_MAX    12'h999
`define RTCS_SEC_MAX   8'h59
`define RTCS_HR_MAX    8'h23
`define RTCS_MON_MAX   8'h12
`define RTCS_YR_MAX    16'h9999
`define RTCS_ONE8      8'h01
`define RTCS_ONE16     16'h0001
`define RTCS_RST_YEAR  16'h2000
`define RTCS_FEB       8'h02
`define RTCS_PSEL_MAX  4'h9
`define RTCS_BASE_W    10

`endif

/* File: rtcs_pkg.sv */
package rtcs_pkg;
    typedef logic [7:0]  rtcs_addr_t;
    typedef logic [31:0] rtcs_word_t;
    typedef logic [2:0]  rtcs_evt_t;
    typedef enum logic {
        RTCS_TMP_LOOP = 1'b0,
        RTCS_TMP_EDGE = 1'b1
    } rtcs_tmp_mode_t;
endpackage

/* File: rtcs_sync.sv */
`timescale 1ns/1ps
module rtcs_sync #(
    parameter int unsigned     W   = 1,
    parameter logic [W-1:0]    RST = '0
) (
    input  wire logic         i_ref_clk, // Clock
    input  wire logic         i_rstn,    // Sync reset, active low
    input  wire logic [W-1:0] i_async,   // Pin levels
    output logic      [W-1:0] o_sync     // Synchronised levels
);
    logic [W-1:0] meta_r;

    // Two-stage synchroniser; the first stage feeds nothing else
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            meta_r <= RST;
            o_sync <= RST;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule

/* File: rtcs_bcd_cnt.sv */
`timescale 1ns/1ps
module rtcs_bcd_cnt #(
    parameter int unsigned      D   = 2,
    parameter logic [4*D-1:0]   RST = '0
) (
    input  wire logic           i_ref_clk,  // Clock
    input  wire logic           i_rstn,     // Sync reset, active low
    input  wire logic           i_inc,      // Count one step
    input  wire logic           i_load,     // Software load
    input  wire logic [4*D-1:0] i_load_val, // Load value, BCD
    input  wire logic [4*D-1:0] i_min,      // Value after rollover
    input  wire logic [4*D-1:0] i_max,      // Last value before rollover
    output logic      [4*D-1:0] o_val,      // Field value, BCD
    output logic                o_wrap      // Carry into next field
);
    // Decimal increment, digit by digit
    function automatic logic [4*D-1:0] bcd_inc(input logic [4*D-1:0] v);
        logic [4*D-1:0] r;
        logic           c;
        r = v;
        c = 1'b1;
        for (int i = 0; i < D; i++) begin
            if (c) begin
                if (v[4*i +: 4] == 4'h9) begin
                    r[4*i +: 4] = 4'h0;
                end else begin
                    r[4*i +: 4] = v[4*i +: 4] + 4'h1;
                    c = 1'b0;
                end
            end
        end
        return r;
    endfunction

    // Compare with >= so a day left past a shorter month still rolls over
    assign o_wrap = i_inc && (o_val >= i_max);

    // Load beats counting so software writes are never lost
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            o_val <= RST;
        end else if (i_load) begin
            o_val <= i_load_val;
        end else if (o_wrap) begin
            o_val <= i_min;
        end else if (i_inc) begin
            o_val <= bcd_inc(o_val);
        end
    end
endmodule

/* File: rtcs_top.sv */
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "rtcs_defs.svh"
module rtcs_top #(
    parameter int unsigned MS_CYCLES   = `RTCS_MS_CYCLES,
    parameter int unsigned BASE_CYCLES = `RTCS_BASE_CYCLES
) (
    input  wire logic               i_ref_clk,                // 100 MHz clock
    input  wire logic               i_rstn,                   // Sync reset, active low
    input  wire rtcs_pkg::rtcs_addr_t i_addr,                 // Register byte address
    input  wire rtcs_pkg::rtcs_word_t i_wdata,                // Write data
    input  wire logic               i_wr,                     // Write strobe
    input  wire logic               i_rd,                     // Read strobe
    output rtcs_pkg::rtcs_word_t    o_rdata,                  // Read data, cycle after strobe
    input  wire logic               i_tamper_pin,             // Tamper input pin, async
    input  wire logic               i_main_power_ok,          // Main supplies present, async
    output logic                    o_irq,                    // Combined interrupt, level
    output logic                    o_debug_return_clock_pin, // Calibration clock out
    output logic                    o_sram_cutoff,            // Cut SRAM standby supply
    output logic                    o_isolated                // Running from backup supply
);
    import rtcs_pkg::*;

    localparam int MSW = $clog2(MS_CYCLES + 1);
    localparam int BSW = $clog2(BASE_CYCLES + 1);

    ////////////////////////////////////////////////////////////////////////////
    // Signals
    logic [MSW-1:0]          ms_div_r;
    logic                    ms_tick_r;
    logic [BSW-1:0]          base_div_r;
    logic                    base_tick_r;
    logic [`RTCS_BASE_W-1:0] base_cnt_r;
    logic [31:0]             ctrl_r;
    logic [31:0]             alarm_r;
    rtcs_evt_t               stat_r;
    rtcs_evt_t               mask_r;
    rtcs_evt_t               evt;
    rtcs_evt_t               w1c;
    logic [23:0]             ts_time_r;
    logic [31:0]             ts_date_r;
    logic [11:0]             ts_ms_r;
    logic                    tmp_s;
    logic                    pwr_s;
    logic                    tmp_q_r;
    logic                    alm_hit_q_r;
    logic [11:0]             ms_v;
    logic [7:0]              sec_v, min_v, hr_v, day_v, mon_v;
    logic [15:0]             yr_v;
    logic                    ms_w, sec_w, min_w, hr_w, day_w, mon_w;
    logic                    wr_ok, ld_time, ld_date, ld_ms;
    logic [7:0]              day_max;
    logic                    alm_hit, alm_evt, per_evt, tmp_evt, tmp_rise, tmp_fall;
    rtcs_word_t              rdata_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Functions
    // BCD two-digit value divisible by four
    function automatic logic bcd_div4(input logic [7:0] v);
        return v[4] ? (v[3:0] == 4'h2 || v[3:0] == 4'h6)
                    : (v[3:0] == 4'h0 || v[3:0] == 4'h4 || v[3:0] == 4'h8);
    endfunction

    // Leap year: divisible by 4, centuries only when divisible by 400
    function automatic logic is_leap(input logic [15:0] y);
        return (y[7:0] == 8'h00) ? bcd_div4(y[15:8]) : bcd_div4(y[7:0]);
    endfunction

    // Last day of the month in BCD
    function automatic logic [7:0] month_days(input logic [7:0] m, input logic [15:0] y);
        case (m)
            8'h02:                        month_days = is_leap(y) ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11:   month_days = 8'h30;
            default:                      month_days = 8'h31;
        endcase
    endfunction

    // Periodic mask: all-ones pattern of base ticks per period
    function automatic logic [`RTCS_BASE_W-1:0] per_mask(input logic [3:0] sel);
        return `RTCS_BASE_W'((1 << (`RTCS_BASE_W - int'(sel))) - 1);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Synchronisers for the pins
    rtcs_sync #(.W(1), .RST(1'b0)) u_sync_tmp (
        .i_ref_clk (i_ref_clk),
        .i_rstn    (i_rstn),
        .i_async   (i_tamper_pin),
        .o_sync    (tmp_s)
    );

    // Power-ok resets high so the block does not flash isolated at startup
    rtcs_sync #(.W(1), .RST(1'b1)) u_sync_pwr (
        .i_ref_clk (i_ref_clk),
        .i_rstn    (i_rstn),
        .i_async   (i_main_power_ok),
        .o_sync    (pwr_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Millisecond prescaler
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            ms_div_r  <= '0;
            ms_tick_r <= 1'b0;
        end else if (ms_div_r == MSW'(MS_CYCLES - 1)) begin
            ms_div_r  <= '0;
            ms_tick_r <= 1'b1;
        end else begin
            ms_div_r  <= ms_div_r + MSW'(1);
            ms_tick_r <= 1'b0;
        end
    end

    // 1024 Hz base for periodic events and calibration output
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            base_div_r  <= '0;
            base_tick_r <= 1'b0;
            base_cnt_r  <= '0;
        end else if (base_div_r == BSW'(BASE_CYCLES - 1)) begin
            base_div_r  <= '0;
            base_tick_r <= 1'b1;
            base_cnt_r  <= base_cnt_r + `RTCS_BASE_W'(1);
        end else begin
            base_div_r  <= base_div_r + BSW'(1);
            base_tick_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Time and calendar counters; counting continues while isolated
    assign wr_ok   = i_wr && !o_isolated;
    assign ld_time = wr_ok && (i_addr == `RTCS_A_TIME);
    assign ld_date = wr_ok && (i_addr == `RTCS_A_DATE);
    assign ld_ms   = wr_ok && (i_addr == `RTCS_A_MSEC);
    assign day_max = month_days(mon_v, yr_v);

    rtcs_bcd_cnt #(.D(3), .RST(12'h000)) u_ms (
        .i_ref_clk (i_ref_clk), .i_rstn (i_rstn), .i_inc (ms_tick_r), .i_load (ld_ms),
        .i_load_val (i_wdata[11:0]), .i_min (12'h000), .i_max (`RTCS_MS_MAX), .o_val (ms_v), .o_wrap (ms_w)
    );
    rtcs_bcd_cnt #(.D(2), .RST(8'h00)) u_sec (
        .i_ref_clk (i_ref_clk), .i_rstn (i_rstn), .i_inc (ms_w), .i_load (ld_time),
        .i_load_val (i_wdata[7:0]), .i_min (8'h00), .i_max (`RTCS_SEC_MAX), .o_val (sec_v), .o_wrap (sec_w)
    );
    rtcs_bcd_cnt #(.D(2), .RST(8'h00)) u_min (
        .i_ref_clk (i_ref_clk), .i_rstn (i_rstn), .i_inc (sec_w), .i_load (ld_time),
        .i_load_val (i_wdata[15:8]), .i_min (8'h00), .i_max (`RTCS_SEC_MAX), .o_val (min_v), .o_wrap (min_w)
    );
    // 24-hour count only
    rtcs_bcd_cnt #(.D(2), .RST(8'h00)) u_hr (
        .i_ref_clk (i_ref_clk), .i_rstn (i_rstn), .i_inc (min_w), .i_load (ld_time),
        .i_load_val (i_wdata[23:16]), .i_min (8'h00), .i_max (`RTCS_HR_MAX), .o_val (hr_v), .o_wrap (hr_w)
    );
    rtcs_bcd_cnt #(.D(2), .RST(`RTCS_ONE8)) u_day (
        .i_ref_clk (i_ref_clk), .i_rstn (i_rstn), .i_inc (hr_w), .i_load (ld_date),
        .i_load_val (i_wdata[7:0]), .i_min (`RTCS_ONE8), .i_max (day_max), .o_val (day_v), .o_wrap (day_w)
    );
    rtcs_bcd_cnt #(.D(2), .RST(`RTCS_ONE8)) u_mon (
        .i_ref_clk (i_ref_clk), .i_rstn (i_rstn), .i_inc (day_w), .i_load (ld_date),
        .i_load_val (i_wdata[15:8]), .i_min (`RTCS_ONE8), .i_max (`RTCS_MON_MAX), .o_val (mon_v), .o_wrap (mon_w)
    );
    // Year 9999 rolls back to 0001
    rtcs_bcd_cnt #(.D(4), .RST(`RTCS_RST_YEAR)) u_yr (
        .i_ref_clk (i_ref_clk), .i_rstn (i_rstn), .i_inc (mon_w), .i_load (ld_date),
        .i_load_val (i_wdata[31:16]), .i_min (`RTCS_ONE16), .i_max (`RTCS_YR_MAX), .o_val (yr_v), .o_wrap ()
    );

    ////////////////////////////////////////////////////////////////////////////
    // Event sources
    // Alarm fires once on entering the matching millisecond
    assign alm_hit = ({day_v, hr_v, min_v, sec_v} == alarm_r) && (ms_v == 12'h000);
    assign alm_evt = ctrl_r[`RTCS_C_ALM_EN] && alm_hit && !alm_hit_q_r;

    // Periodic rate is 2^sel Hz, sel 0..9
    assign per_evt = ctrl_r[`RTCS_C_PER_EN] && base_tick_r
                   && ((base_cnt_r & per_mask(ctrl_r[`RTCS_C_PSEL_HI:`RTCS_C_PSEL_LO]))
                       == per_mask(ctrl_r[`RTCS_C_PSEL_HI:`RTCS_C_PSEL_LO]));

    // Tamper detection sits here, next to the time it stamps
    assign tmp_rise = tmp_s && !tmp_q_r;
    assign tmp_fall = !tmp_s && tmp_q_r;
    always_comb begin
        tmp_evt = 1'b0;
        if (ctrl_r[`RTCS_C_TMP_EN]) begin
            if (rtcs_tmp_mode_t'(ctrl_r[`RTCS_C_TMP_MD]) == RTCS_TMP_EDGE) begin
                tmp_evt = ctrl_r[`RTCS_C_TMP_POL] ? tmp_rise : tmp_fall;
            end else begin
                // Open loop pulls the pin high; re-flags while open after a clear
                tmp_evt = tmp_s && !stat_r[`RTCS_S_TMP];
            end
        end
    end

    assign evt = {per_evt, tmp_evt, alm_evt};
    assign w1c = (wr_ok && i_addr == `RTCS_A_STAT) ? i_wdata[2:0] : 3'h0;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            tmp_q_r     <= 1'b0;
            alm_hit_q_r <= 1'b0;
        end else begin
            tmp_q_r     <= tmp_s;
            alm_hit_q_r <= alm_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Tamper stamp and SRAM cut-off, taken in the same cycle
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            ts_time_r <= '0;
            ts_date_r <= '0;
            ts_ms_r   <= '0;
        end else if (tmp_evt) begin
            ts_time_r <= {hr_v, min_v, sec_v};
            ts_date_r <= {yr_v, mon_v, day_v};
            ts_ms_r   <= ms_v;
        end
    end

    // Restore only takes effect without a tamper in the same cycle
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            o_sram_cutoff <= 1'b0;
        end else if (tmp_evt) begin
            o_sram_cutoff <= 1'b1;
        end else if (wr_ok && i_addr == `RTCS_A_CTRL && i_wdata[`RTCS_C_RESTORE]) begin
            o_sram_cutoff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software registers
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            ctrl_r  <= '0;
            alarm_r <= '0;
            mask_r  <= '0;
        end else if (wr_ok) begin
            case (i_addr)
                `RTCS_A_CTRL: begin
                    // Restore and upper bits are pulses or unused, so they read back as zero
                    ctrl_r <= 32'(i_wdata[`RTCS_C_PSEL_HI:0]);
                    // Clamp rate select to 512 Hz
                    if (i_wdata[`RTCS_C_PSEL_HI:`RTCS_C_PSEL_LO] > `RTCS_PSEL_MAX) begin
                        ctrl_r[`RTCS_C_PSEL_HI:`RTCS_C_PSEL_LO] <= `RTCS_PSEL_MAX;
                    end
                end
                `RTCS_A_ALARM: alarm_r <= i_wdata;
                `RTCS_A_MASK:  mask_r  <= i_wdata[2:0];
                default: begin
                end
            endcase
        end
    end

    // Sticky flags: a new event wins over a clear in the same cycle
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            stat_r <= '0;
        end else begin
            stat_r <= (stat_r & ~w1c) | evt;
        end
    end

    // Outputs: interrupt, isolation, calibration clock
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            o_irq                    <= 1'b0;
            o_isolated               <= 1'b0;
            o_debug_return_clock_pin <= 1'b0;
        end else begin
            o_irq                    <= |(stat_r & mask_r);
            o_isolated               <= !pwr_s;
            o_debug_return_clock_pin <= ctrl_r[`RTCS_C_CAL_EN] && base_cnt_r[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path; unmapped addresses read zero
    always_comb begin
        case (i_addr)
            `RTCS_A_CTRL:    rdata_nxt = ctrl_r;
            `RTCS_A_TIME:    rdata_nxt = {8'h00, hr_v, min_v, sec_v};
            `RTCS_A_DATE:    rdata_nxt = {yr_v, mon_v, day_v};
            `RTCS_A_MSEC:    rdata_nxt = {20'h0_0000, ms_v};
            `RTCS_A_ALARM:   rdata_nxt = alarm_r;
            `RTCS_A_STAT:    rdata_nxt = {22'h0, o_isolated, o_sram_cutoff, 5'h00, stat_r};
            `RTCS_A_MASK:    rdata_nxt = {29'h0, mask_r};
            `RTCS_A_TS_TIME: rdata_nxt = {8'h00, ts_time_r};
            `RTCS_A_TS_DATE: rdata_nxt = ts_date_r;
            `RTCS_A_TS_MSEC: rdata_nxt = {20'h0_0000, ts_ms_r};
            default:         rdata_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= i_rd ? rdata_nxt : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    sequence s_tamper_hit;
        tmp_evt;
    endsequence
    sequence s_stamp_taken;
        (ts_ms_r == $past(ms_v)) && (ts_time_r == $past({hr_v, min_v, sec_v}));
    endsequence

    ms_tick_align_a: assert property (ms_tick_r |-> ms_div_r == '0 ##1 !ms_tick_r)
        else $error("millisecond tick out of step");
    ms_carry_a: assert property (ms_tick_r && ms_v == 12'h999 && !ld_ms && !ld_time
                                 |=> ms_v == 12'h000 && sec_v != $past(sec_v))
        else $error("millisecond carry lost");
    hour_range_a: assert property (hr_v <= 8'h23)
        else $error("hour above 23");
    bcd_digits_a: assert property (sec_v[3:0] <= 4'h9 && min_v[3:0] <= 4'h9 && ms_v[3:0] <= 4'h9)
        else $error("non-decimal digit in time");
    leap_day_a: assert property (hr_w && mon_v == `RTCS_FEB && day_v == 8'h28 && is_leap(yr_v) && !ld_date
                                 |=> day_v == 8'h29)
        else $error("leap day skipped");
    alarm_flag_a: assert property (alm_evt |=> stat_r[`RTCS_S_ALM] ##1 o_irq || !mask_r[`RTCS_S_ALM])
        else $error("alarm event not flagged");
    periodic_flag_a: assert property (per_evt |=> stat_r[`RTCS_S_PER])
        else $error("periodic event not flagged");
    tamper_stamp_a: assert property (s_tamper_hit |=> s_stamp_taken)
        else $error("tamper stamp wrong");
    sram_cut_a: assert property (s_tamper_hit |=> o_sram_cutoff && stat_r[`RTCS_S_TMP])
        else $error("sram not cut on tamper");
    tamper_edge_a: assert property (ctrl_r[`RTCS_C_TMP_EN] && ctrl_r[`RTCS_C_TMP_MD] && ctrl_r[`RTCS_C_TMP_POL]
                                    && $rose(tmp_s) |-> tmp_evt)
        else $error("rising tamper edge missed");
    irq_or_a: assert property (|(stat_r & mask_r) |=> o_irq)
        else $error("interrupt not raised");
    cal_off_a: assert property (!ctrl_r[`RTCS_C_CAL_EN] |=> !o_debug_return_clock_pin)
        else $error("calibration clock while disabled");
    isolate_a: assert property (!pwr_s |=> o_isolated)
        else $error("isolation not entered");
endmodule

/* File: rtcs_tsw.sv */
`timescale 1ns/1ps
module rtcs_tsw (
    input  wire logic i_ref_clk, // Clock
    input  wire logic i_open,    // Commanded contact state, 1 = open or high
    output logic      o_pin      // Level seen at the tamper pin
);
    // Contact follows the command one clock late, like a slow mechanical switch
    always_ff @(posedge i_ref_clk) begin
        o_pin <= i_open;
    end
endmodule

/* File: testbench.sv */
`timescale 1ns/1ps
`define CHK(n, e, a) check(n, e, a)
`define WT(c, n) begin int k; for (k = 0; k < n && (c) !== 1'b1; k++) begin @(posedge clk); #1; end if ((c) !== 1'b1) timeout(); end
module testbench;
    import rtcs_pkg::*;
    typedef struct {rtcs_addr_t a; logic w; rtcs_word_t d; rtcs_word_t e;} rtcs_row_t;
    logic       clk = 0, rstn = 0, wr = 0, rd = 0, open = 0, pwr = 1;
    logic       irq, cal, cut, iso, pin;
    rtcs_addr_t addr = '0;
    rtcs_word_t wdata = '0, rdata;
    int         n_fail = 0, check_count = 0;
    rtcs_row_t  rows[10] = '{'{8'h00, 0, '0, '0}, '{8'h08, 0, '0, 32'h2000_0101}, '{8'h14, 0, '0, '0},
        '{8'h18, 0, '0, '0}, '{8'h1C, 0, '0, '0}, '{8'h40, 0, '0, '0}, '{8'h14, 1, 32'h0000_0300, '0},
        '{8'h18, 1, 32'h0000_0007, 32'h0000_0007}, '{8'h10, 1, 32'h3123_5959, 32'h3123_5959},
        '{8'h00, 1, 32'h0000_07C0, 32'h0000_0240}};
    rtcs_word_t dt[4][2] = '{'{32'h2000_0228, 32'h2000_0229}, '{32'h2001_0228, 32'h2001_0301},
        '{32'h2100_0228, 32'h2100_0301}, '{32'h9999_1231, 32'h0001_0101}};
    rtcs_word_t tc[3] = '{32'h0000_001C, 32'h0000_000C, 32'h0000_0004};
    logic       tp[3] = '{1, 0, 1};

    // Short counts keep a simulated second near ten thousand cycles
    rtcs_top #(.MS_CYCLES(10), .BASE_CYCLES(4)) dut (.i_ref_clk(clk), .i_rstn(rstn), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_tamper_pin(pin), .i_main_power_ok(pwr),
        .o_irq(irq), .o_debug_return_clock_pin(cal), .o_sram_cutoff(cut), .o_isolated(iso));
    rtcs_tsw sw (.i_ref_clk(clk), .i_open(open), .o_pin(pin));

    ////////////////////////////////////////////////////////////////////////
    // Clock, 100 MHz
    always #5 clk = ~clk;

    task automatic check(string n, rtcs_word_t e, rtcs_word_t a);
        check_count++;
        if (a !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", n, e, a);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic timeout();
        n_fail++;
        $display("[FAIL] wait bound used up");
        end_of_test();
    endtask
    // Bus cycles: strobe one cycle, read data sampled in the cycle after
    task automatic wreg(rtcs_addr_t a, rtcs_word_t d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1;
        @(posedge clk);
        wr <= 0;
    endtask
    task automatic rchk(rtcs_addr_t a, rtcs_word_t e);
        @(posedge clk);
        addr <= a;
        rd <= 1;
        @(posedge clk);
        rd <= 0;
        #1 check($sformatf("reg %h", a), e, rdata);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence; reset held two edges, the pin synchronisers reset to their idle levels
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1;
        #1 `CHK("outputs", '0, {irq, cal, cut, iso});
        foreach (rows[i]) begin
            if (rows[i].w) begin
                wreg(rows[i].a, rows[i].d);
            end
            rchk(rows[i].a, rows[i].e);
        end
        for (int i = 0; i < 4; i++) begin
            wreg(8'h04, 32'h0023_5959);
            wreg(8'h08, dt[i][0]);
            wreg(8'h0C, 32'h0000_0998);
            repeat (30) @(posedge clk);
            rchk(8'h08, dt[i][1]);
            rchk(8'h04, '0);
        end
        // Rising, falling, then loop mode; tamper disabled on restore so an open loop cannot refire
        wreg(8'h18, 32'h0000_0002);
        for (int i = 0; i < 3; i++) begin
            wreg(8'h00, tc[i]);
            open <= tp[i];
            `WT(cut, 10)
            rchk(8'h14, 32'h0000_0102);
            `CHK("tamper irq", 1, irq);
            rchk(8'h20, 32'h0001_0101);
            rchk(8'h1C, '0);
            wreg(8'h00, 32'h0000_0400);
            wreg(8'h14, 32'h0000_0002);
            rchk(8'h14, '0);
            `CHK("cutoff irq", '0, {cut, irq});
        end
        wreg(8'h18, '0);
        wreg(8'h00, 32'h0000_0242);
        repeat (20) @(posedge clk);
        rchk(8'h14, 32'h0000_0004);
        `CHK("masked irq", '0, irq);
        wreg(8'h18, 32'h0000_0004);
        `WT(irq, 4)
        wreg(8'h00, '0);
        wreg(8'h14, 32'h0000_0004);
        wreg(8'h08, 32'h2000_0101);
        wreg(8'h04, '0);
        wreg(8'h0C, '0);
        wreg(8'h10, 32'h0100_0001);
        wreg(8'h18, 32'h0000_0001);
        wreg(8'h00, 32'h0000_0001);
        `WT(irq, 12000)
        rchk(8'h14, 32'h0000_0001);
        rchk(8'h04, 32'h0000_0001);
        wreg(8'h00, 32'h0000_0020);
        wreg(8'h14, 32'h0000_0001);
        `WT(cal, 20)
        `WT(!cal, 20)
        wreg(8'h00, '0);
        pwr <= 0;
        `WT(iso, 10)
        wreg(8'h18, 32'h0000_0007);
        rchk(8'h18, 32'h0000_0001);
        rchk(8'h14, 32'h0000_0200);
        pwr <= 1;
        `WT(!iso, 10)
        end_of_test();
    end
endmodule
